// File: rtl/rsdm_consts.svh
// Constants for the reader serial port and direct-mode control.
// Assumes inclusion by the top module only.
// Overview of operation
// - Serial logic held in reset whenever slave select is high.
// - Master changes data on rising clock; device samples on falling clock.
// - Rising slave select ends the current communication.
// - Every serial word is eight bits, most significant bit first.
// - Output carries no valid data while the command byte shifts in.
// - After eighth falling edge, read data leaves on falling edges, MSB first.
// - Interrupt status read after transmit completion returns only transmit-done flag.
// - Direct bit clear: modulation pin drives modulator, envelope to receive pin.
// - Direct bit set: decoded bit stream and bit clock go to pins.
// - Writing chip state direct bit to one enters direct mode immediately.
// - Any stop ends direct mode and clears the chip state direct bit.
// - Front-end-only mode blocks register, FIFO and interrupt access.
// - Protocol codes 0x02, 0x08, 0x1a and 0x1b are decoded.
// - Modulator code 0x21 selects OOK; 0x20,0x22-0x25 select ASK depths.
// - No FIFO use or interrupts in direct mode; master codes frames.
// - Modulation kind pin low selects ASK, high selects OOK; outside direct mode the modulator register decides.
// - Formatted mode passes raw data bytes through the 127-byte FIFO; the code's FIFO holds FIFO_DEPTH bytes, 4 by default.
`ifndef RSDM_CONSTS_SVH
`define RSDM_CONSTS_SVH
`define RSDM_ADR_CHIP 5'h00
`define RSDM_ADR_PROTO 5'h01
`define RSDM_ADR_NRWAIT 5'h07
`define RSDM_ADR_RXWAIT 5'h08
`define RSDM_ADR_MODCLK 5'h09
`define RSDM_ADR_RXSPEC 5'h0a
`define RSDM_ADR_IRQ 5'h0c
`define RSDM_ADR_MASK 5'h0d
`define RSDM_ADR_FIFOST 5'h1c
`define RSDM_ADR_FIFO 5'h1f
`define RSDM_CMD_FIFO_RESET 5'h0f
`define RSDM_BIT_CMD 7
`define RSDM_BIT_READ 6
`define RSDM_BIT_CONT 5
`define RSDM_BIT_DIRECT 6
`define RSDM_IRQ_TX_DONE 8'h80
`define RSDM_IRQ_RX_DONE 8'h40
`define RSDM_RST_CHIP 8'h01
`define RSDM_RST_PROTO 8'h02
`define RSDM_RST_NRWAIT 8'h0e
`define RSDM_RST_RXWAIT 8'h07
`define RSDM_RST_MODCLK 8'h11
`define RSDM_RST_RXSPEC 8'h40
`define RSDM_PROTO_VHDR 5'h02
`define RSDM_PROTO_A106 5'h08
`define RSDM_PROTO_F212 5'h1a
`define RSDM_PROTO_F424 5'h1b
`define RSDM_MOD_ASK10 3'h0
`define RSDM_MOD_OOK 3'h1
`define RSDM_MOD_ASK7 3'h2
`define RSDM_MOD_ASK85 3'h3
`define RSDM_MOD_ASK13 3'h4
`define RSDM_MOD_ASK16 3'h5
`define RSDM_FIFO_BYTES 127
`endif

// File: rtl/rsdm_pkg.sv
// Types for the reader serial port and direct-mode control.
// Assumes the consts header is on the include path.
package rsdm_pkg;
	typedef enum logic [1:0] {
		RSDM_PH_CMD,
		RSDM_PH_DATA,
		RSDM_PH_DUMMY
	} rsdm_phase_t;
	typedef enum logic [2:0] {
		RSDM_PROTO_OTHER,
		RSDM_PROTO_VHD,
		RSDM_PROTO_A,
		RSDM_PROTO_F212,
		RSDM_PROTO_F424
	} rsdm_proto_t;
	typedef enum logic [1:0] {
		RSDM_RT_NORMAL,
		RSDM_RT_FRONT_END,
		RSDM_RT_DECODED
	} rsdm_route_t;
endpackage

// File: rtl/rsdm_fifo.sv
// Byte FIFO of flip-flops with valid and ready on both sides.
// Assumes one clock and a synchronous clear from the owner.
`timescale 1ns/100ps
module rsdm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic clr_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);
	initial begin
		if (DEPTH < 2 || WIDTH < 1) $error("rsdm_fifo: bad size");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic push;
	logic pop;
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
	endfunction
	assign in_ready_o = (cnt_q != CW'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign count_o = cnt_q;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (clr_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wr_q <= bump(wr_q);
			if (pop) rd_q <= bump(rd_q);
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end
endmodule

// File: rtl/rsdm_top.sv
// Serial slave port, register file and direct-mode pin routing of the reader.
// Assumes slave select, serial clock and data arrive asynchronous to mclk_i.
`timescale 1ns/100ps
`include "rsdm_consts.svh"
module rsdm_top #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic ss_b_i,
	input wire logic sclk_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_b_o,
	input wire logic modulation_input_i,
	input wire logic modulation_kind_select_i,
	input wire logic envelope_i,
	input wire logic dec_data_i,
	input wire logic dec_clk_i,
	output logic modulator_o,
	output logic ook_o,
	output logic [2:0] ask_depth_o,
	output logic rx_data_o,
	output logic rx_data_oe_b_o,
	output logic bit_clk_o,
	output logic bit_clk_oe_b_o,
	output rsdm_pkg::rsdm_proto_t proto_o,
	output rsdm_pkg::rsdm_route_t route_o,
	input wire logic tx_done_i,
	input wire logic rx_done_i,
	input wire logic rx_byte_valid_i,
	input wire logic [7:0] rx_byte_i,
	output logic rx_byte_ready_o,
	output logic irq_o,
	output logic fifo_reset_o
);
	import rsdm_pkg::*;
	initial begin
		if (FIFO_DEPTH < 2 || FIFO_DEPTH > `RSDM_FIFO_BYTES) $error("rsdm_top: bad depth");
	end
	localparam int CW = $clog2(FIFO_DEPTH+1);

	// Reset release and pin synchronisers
	logic [1:0] rs_q;
	logic rst_b;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) rs_q <= 2'h0;
		else rs_q <= {rs_q[0], 1'b1};
	end
	assign rst_b = rs_q[1];
	logic [2:0] s1_q, s2_q;
	logic [3:0] p1_q, p2_q;
	logic sclk_d1_q;
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			// Reset matches the idle pins, so no false clock edge follows reset
			s1_q <= 3'h4;
			s2_q <= 3'h4;
			p1_q <= 4'h0;
			p2_q <= 4'h0;
			sclk_d1_q <= 1'b0;
		end else begin
			s1_q <= {ss_b_i, sclk_i, mosi_i};
			s2_q <= s1_q;
			p1_q <= {modulation_kind_select_i, modulation_input_i, dec_data_i, dec_clk_i};
			p2_q <= p1_q;
			sclk_d1_q <= s2_q[1];
		end
	end
	logic ss_b, mosi, sclk_fall, ss_b_d_q, ss_rise;
	assign ss_b = s2_q[2];
	assign mosi = s2_q[0];
	assign sclk_fall = sclk_d1_q && !s2_q[1] && !ss_b;
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) ss_b_d_q <= 1'b1;
		else ss_b_d_q <= ss_b;
	end
	assign ss_rise = ss_b && !ss_b_d_q;

	// Registers
	logic [7:0] chip_q, proto_q, nrwait_q, rxwait_q, modclk_q, rxspec_q, irq_q, mask_q;
	logic direct;
	assign direct = chip_q[`RSDM_BIT_DIRECT];
	logic front_end;
	assign front_end = direct && !proto_q[`RSDM_BIT_DIRECT];

	// Serial engine
	rsdm_phase_t ph_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q, tx_q;
	logic [4:0] adr_q;
	logic rd_q, cont_q, irq_read_q;
	logic byte_done;
	logic [7:0] rx_word;
	assign byte_done = sclk_fall && (bit_q == 3'h7);
	assign rx_word = {sh_q[6:0], mosi};

	// FIFO signals
	logic fifo_out_valid, fifo_pop, fifo_clr;
	logic [7:0] fifo_data;
	logic [CW-1:0] fifo_cnt;
	logic fifo_load_q;

	function automatic logic [7:0] reg_read(input logic [4:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == `RSDM_ADR_CHIP) v = chip_q;
		else if (a == `RSDM_ADR_PROTO) v = proto_q;
		else if (a == `RSDM_ADR_NRWAIT) v = nrwait_q;
		else if (a == `RSDM_ADR_RXWAIT) v = rxwait_q;
		else if (a == `RSDM_ADR_MODCLK) v = modclk_q;
		else if (a == `RSDM_ADR_RXSPEC) v = rxspec_q;
		else if (a == `RSDM_ADR_IRQ) v = irq_q;
		else if (a == `RSDM_ADR_MASK) v = mask_q;
		else if (a == `RSDM_ADR_FIFOST) v = 8'(fifo_cnt);
		else if (a == `RSDM_ADR_FIFO) v = fifo_data;
		reg_read = v;
	endfunction

	logic wr_stb, cmd_stb;
	logic [4:0] wr_adr;
	always_comb begin
		wr_stb = 1'b0;
		cmd_stb = 1'b0;
		wr_adr = adr_q;
		if (byte_done && !front_end) begin
			if (ph_q == RSDM_PH_CMD) begin
				cmd_stb = rx_word[`RSDM_BIT_CMD];
				wr_adr = rx_word[4:0];
			end else if (ph_q == RSDM_PH_DATA && !rd_q) begin
				wr_stb = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			ph_q <= RSDM_PH_CMD;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			adr_q <= 5'h00;
			rd_q <= 1'b0;
			cont_q <= 1'b0;
			irq_read_q <= 1'b0;
		end else if (ss_b) begin
			ph_q <= RSDM_PH_CMD;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			irq_read_q <= 1'b0;
		end else if (sclk_fall && !front_end) begin
			bit_q <= bit_q + 3'h1;
			sh_q <= rx_word;
			tx_q <= {tx_q[6:0], 1'b0};
			if (byte_done) begin
				if (ph_q == RSDM_PH_CMD) begin
					adr_q <= rx_word[4:0];
					rd_q <= rx_word[`RSDM_BIT_READ];
					cont_q <= rx_word[`RSDM_BIT_CONT];
					if (rx_word[`RSDM_BIT_CMD]) begin
						ph_q <= RSDM_PH_DUMMY;
					end else begin
						ph_q <= RSDM_PH_DATA;
						tx_q <= reg_read(rx_word[4:0]);
					end
				end else if (ph_q == RSDM_PH_DATA) begin
					if (rd_q && adr_q == `RSDM_ADR_IRQ) irq_read_q <= 1'b1;
					if (cont_q && adr_q != `RSDM_ADR_FIFO) begin
						adr_q <= adr_q + 5'h1;
						tx_q <= reg_read(adr_q + 5'h1);
					end else begin
						tx_q <= reg_read(adr_q);
					end
				end
			end
		end else if (fifo_load_q) begin
			// The popped head leaves only at the pop edge, so the next byte loads a cycle later
			tx_q <= fifo_data;
		end
	end
	assign fifo_pop = byte_done && !front_end && ph_q == RSDM_PH_DATA && rd_q
		&& adr_q == `RSDM_ADR_FIFO;
	assign fifo_clr = cmd_stb && wr_adr == `RSDM_CMD_FIFO_RESET;
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) fifo_load_q <= 1'b0;
		else fifo_load_q <= fifo_pop && fifo_out_valid;
	end

	// Status clears one byte after it was read, so the dummy clocks are needed
	logic irq_clr;
	assign irq_clr = irq_read_q && byte_done && !front_end;
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 8'h00;
		end else begin
			irq_q <= (irq_clr ? 8'h00 : irq_q)
				| ((tx_done_i && !direct) ? `RSDM_IRQ_TX_DONE : 8'h00)
				| ((rx_done_i && !direct) ? `RSDM_IRQ_RX_DONE : 8'h00);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			chip_q <= `RSDM_RST_CHIP;
			proto_q <= `RSDM_RST_PROTO;
			nrwait_q <= `RSDM_RST_NRWAIT;
			rxwait_q <= `RSDM_RST_RXWAIT;
			modclk_q <= `RSDM_RST_MODCLK;
			rxspec_q <= `RSDM_RST_RXSPEC;
			mask_q <= 8'h00;
		end else begin
			if (ss_rise) chip_q[`RSDM_BIT_DIRECT] <= 1'b0;
			else if (wr_stb && adr_q == `RSDM_ADR_CHIP) chip_q <= rx_word;
			if (wr_stb && adr_q == `RSDM_ADR_PROTO) proto_q <= rx_word;
			if (wr_stb && adr_q == `RSDM_ADR_NRWAIT) nrwait_q <= rx_word;
			if (wr_stb && adr_q == `RSDM_ADR_RXWAIT) rxwait_q <= rx_word;
			if (wr_stb && adr_q == `RSDM_ADR_MODCLK) modclk_q <= rx_word;
			if (wr_stb && adr_q == `RSDM_ADR_RXSPEC) rxspec_q <= rx_word;
			if (wr_stb && adr_q == `RSDM_ADR_MASK) mask_q <= rx_word;
		end
	end

	// Receive buffer; the registered ready looks one push ahead so it never overfills
	logic fifo_push;
	assign fifo_push = rx_byte_valid_i && rx_byte_ready_o && !direct;
	rsdm_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(mclk_i),
		.rst_b_i(rst_b),
		.clr_i(fifo_clr),
		.in_valid_i(fifo_push),
		.in_ready_o(),
		.in_data_i(rx_byte_i),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data),
		.count_o(fifo_cnt)
	);

	function automatic rsdm_proto_t proto_decode(input logic [4:0] c);
		if (c == `RSDM_PROTO_VHDR) proto_decode = RSDM_PROTO_VHD;
		else if (c == `RSDM_PROTO_A106) proto_decode = RSDM_PROTO_A;
		else if (c == `RSDM_PROTO_F212) proto_decode = RSDM_PROTO_F212;
		else if (c == `RSDM_PROTO_F424) proto_decode = RSDM_PROTO_F424;
		else proto_decode = RSDM_PROTO_OTHER;
	endfunction

	// Output registers; envelope is re-timed by one cycle, pins cross the synchroniser first
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			miso_o <= 1'b0;
			miso_oe_b_o <= 1'b1;
			modulator_o <= 1'b0;
			ook_o <= 1'b0;
			ask_depth_o <= `RSDM_MOD_ASK10;
			rx_data_o <= 1'b0;
			rx_data_oe_b_o <= 1'b1;
			bit_clk_o <= 1'b0;
			bit_clk_oe_b_o <= 1'b1;
			proto_o <= RSDM_PROTO_OTHER;
			route_o <= RSDM_RT_NORMAL;
			rx_byte_ready_o <= 1'b0;
			irq_o <= 1'b0;
			fifo_reset_o <= 1'b0;
		end else begin
			miso_o <= (ph_q == RSDM_PH_DATA && rd_q) ? tx_q[7] : 1'b0;
			miso_oe_b_o <= ss_b;
			modulator_o <= direct ? p2_q[2] : 1'b0;
			ook_o <= direct ? p2_q[3]
				: (modclk_q[2:0] == `RSDM_MOD_OOK);
			ask_depth_o <= modclk_q[2:0];
			proto_o <= proto_decode(proto_q[4:0]);
			if (front_end) begin
				rx_data_o <= envelope_i;
				bit_clk_o <= 1'b0;
				route_o <= RSDM_RT_FRONT_END;
			end else if (direct) begin
				rx_data_o <= p2_q[1];
				bit_clk_o <= p2_q[0];
				route_o <= RSDM_RT_DECODED;
			end else begin
				rx_data_o <= 1'b0;
				bit_clk_o <= 1'b0;
				route_o <= RSDM_RT_NORMAL;
			end
			rx_data_oe_b_o <= !direct;
			bit_clk_oe_b_o <= !(direct && !front_end);
			rx_byte_ready_o <= !direct && (fifo_cnt + CW'(fifo_push)) != CW'(FIFO_DEPTH);
			irq_o <= (irq_q & ~mask_q) != 8'h00 && !direct;
			fifo_reset_o <= fifo_clr;
		end
	end
endmodule

// File: tb/rsdm_checker.sv
// Assertions on the serial port and direct-mode pins of rsdm_top.
// Assumes it is bound to rsdm_top and sees only that module's ports.
`timescale 1ns/100ps
module rsdm_checker (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic ss_b_i,
	input wire logic sclk_i,
	input wire logic miso_o,
	input wire logic miso_oe_b_o,
	input wire logic modulation_input_i,
	input wire logic envelope_i,
	input wire logic dec_data_i,
	input wire logic modulator_o,
	input wire logic rx_data_o,
	input wire logic rx_data_oe_b_o,
	input wire logic bit_clk_oe_b_o,
	input wire logic irq_o,
	input wire rsdm_pkg::rsdm_route_t route_o
);
	import rsdm_pkg::*;
	logic sclk_q;
	logic [3:0] since_fall_q;
	// Pin-level edge age; the port sees the edge only after its synchroniser
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sclk_q <= 1'b0;
			since_fall_q <= 4'hf;
		end else begin
			sclk_q <= sclk_i;
			if (sclk_q && !sclk_i) since_fall_q <= 4'h0;
			else if (since_fall_q != 4'hf) since_fall_q <= since_fall_q + 4'h1;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	sequence s_front(a);
		(route_o == RSDM_RT_FRONT_END && $stable(a)) [*3];
	endsequence
	sequence s_dec;
		(route_o == RSDM_RT_DECODED && $stable(dec_data_i)) [*5];
	endsequence
	chk_ss_idle_out: assert property (ss_b_i [*6] |-> miso_oe_b_o && !miso_o)
		else $error("serial output active while deselected");
	chk_miso_bit_hold: assert property ($changed(miso_o) && !ss_b_i |-> since_fall_q inside {[1:8]})
		else $error("serial output changed away from a falling clock");
	chk_stop_exit: assert property ($rose(ss_b_i) |-> ##[1:8] route_o == RSDM_RT_NORMAL)
		else $error("stop did not end direct mode");
	chk_front_mod: assert property (s_front(modulation_input_i) |-> modulator_o == modulation_input_i)
		else $error("modulator not following modulation pin");
	chk_front_rx: assert property (s_front(envelope_i) |-> rx_data_o == envelope_i && !rx_data_oe_b_o)
		else $error("receive pin not carrying envelope");
	chk_dec_route: assert property (s_dec |-> rx_data_o == dec_data_i && !rx_data_oe_b_o)
		else $error("receive pin not carrying decoded stream");
	chk_bitclk_off: assert property ((route_o != RSDM_RT_DECODED) [*2] |-> bit_clk_oe_b_o)
		else $error("bit clock pin driven outside decoded mode");
	chk_direct_quiet: assert property ((route_o != RSDM_RT_NORMAL) [*3] |-> !irq_o)
		else $error("interrupt raised in direct mode");
endmodule
bind rsdm_top rsdm_checker u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ss_b_i(ss_b_i),
	.sclk_i(sclk_i), .miso_o(miso_o), .miso_oe_b_o(miso_oe_b_o), .envelope_i(envelope_i),
	.modulation_input_i(modulation_input_i), .dec_data_i(dec_data_i), .irq_o(irq_o),
	.modulator_o(modulator_o), .rx_data_o(rx_data_o), .rx_data_oe_b_o(rx_data_oe_b_o),
	.bit_clk_oe_b_o(bit_clk_oe_b_o), .route_o(route_o));

// File: tb/rsdm_mcu_model.sv
// Serial master model standing for the microcontroller.
// Assumes mclk_i is the bench clock; all pin changes land on its falling edge.
`timescale 1ns/100ps
module rsdm_mcu_model (
	input wire logic mclk_i,
	input wire logic miso_i,
	output logic ss_b_o,
	output logic sclk_o,
	output logic mosi_o
);
	int half = 4;
	initial begin
		ss_b_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	task automatic sel();
		wt(1);
		ss_b_o = 1'b0;
		wt(4);
	endtask
	// Clock idles low; data moves with the rising edge, read just before the fall
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_o = 1'b1;
			mosi_o = tx[i];
			wt(half);
			rx[i] = miso_i;
			sclk_o = 1'b0;
			wt(half);
		end
	endtask
	// Released data line shows the inverse so a stale bit cannot pass
	task automatic stop();
		ss_b_o = 1'b1;
		mosi_o = ~mosi_o;
		wt(8);
	endtask
	task automatic idle_clocks();
		for (int i = 0; i < 8; i++) begin
			sclk_o = 1'b1;
			mosi_o = ~mosi_o;
			wt(4);
			sclk_o = 1'b0;
			wt(4);
		end
	endtask
endmodule

// File: tb/rsdm_tb_top.sv
// Self-checking bench for the reader serial port and direct-mode control.
// Assumes rsdm_top with a 4-word FIFO and the master model beside it.
`timescale 1ns/100ps
module rsdm_tb_top;
	import rsdm_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_b_i, ss_b_i, sclk_i, mosi_i, miso_o, miso_oe_b_o, modulation_input_i;
	logic modulation_kind_select_i, envelope_i, dec_data_i, dec_clk_i, modulator_o, ook_o;
	logic rx_data_o, rx_data_oe_b_o, bit_clk_o, bit_clk_oe_b_o, tx_done_i, rx_done_i;
	logic rx_byte_valid_i, rx_byte_ready_o, irq_o, fifo_reset_o;
	logic [2:0] ask_depth_o;
	logic [7:0] rx_byte_i, r;
	rsdm_proto_t proto_o;
	rsdm_route_t route_o;
	int mismatches = 0;
	int checks_done = 0;
	int n = 0;
	logic fifo_rst_seen = 1'b0;
	logic [4:0] ra [7] = '{5'h00, 5'h01, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h05};
	logic [7:0] rv [7] = '{8'h01, 8'h02, 8'h0e, 8'h07, 8'h11, 8'h40, 8'h00};
	logic [7:0] pc [5] = '{8'h02, 8'h08, 8'h1a, 8'h1b, 8'h00};
	rsdm_proto_t pe [5] = '{RSDM_PROTO_VHD, RSDM_PROTO_A, RSDM_PROTO_F212, RSDM_PROTO_F424,
		RSDM_PROTO_OTHER};
	always #20 mclk_i = ~mclk_i;
	// The reset pulse lasts one cycle, so it is caught in a sticky flag
	always @(posedge mclk_i) begin
		if (fifo_reset_o === 1'b1) fifo_rst_seen <= 1'b1;
	end
	rsdm_top #(.FIFO_DEPTH(4)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ss_b_i(ss_b_i),
		.sclk_i(sclk_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_b_o(miso_oe_b_o),
		.modulation_input_i(modulation_input_i), .envelope_i(envelope_i),
		.modulation_kind_select_i(modulation_kind_select_i), .dec_data_i(dec_data_i),
		.dec_clk_i(dec_clk_i), .modulator_o(modulator_o), .ook_o(ook_o),
		.ask_depth_o(ask_depth_o), .rx_data_o(rx_data_o), .rx_data_oe_b_o(rx_data_oe_b_o),
		.bit_clk_o(bit_clk_o), .bit_clk_oe_b_o(bit_clk_oe_b_o), .proto_o(proto_o),
		.route_o(route_o), .tx_done_i(tx_done_i), .rx_done_i(rx_done_i),
		.rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i),
		.rx_byte_ready_o(rx_byte_ready_o), .irq_o(irq_o), .fifo_reset_o(fifo_reset_o));
	rsdm_mcu_model u_mcu (.mclk_i(mclk_i), .miso_i(miso_o), .ss_b_o(ss_b_i), .sclk_o(sclk_i),
		.mosi_o(mosi_i));
	task automatic results();
		if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got 0x%h expected 0x%h", $time, got, exp);
		end
	endtask
	// Hold keeps select low so the write can open direct mode
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input bit hold);
		u_mcu.sel();
		u_mcu.xfer({3'b000, a}, r);
		u_mcu.xfer(d, r);
		if (!hold) u_mcu.stop();
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		u_mcu.sel();
		u_mcu.xfer({3'b010, a}, r);
		u_mcu.xfer(8'h00, r);
		u_mcu.stop();
		chk(r, exp);
	endtask
	task automatic pulse_tx();
		tx_done_i = 1'b1;
		u_mcu.wt(1);
		tx_done_i = 1'b0;
		u_mcu.wt(4);
	endtask
	initial begin
		repeat (40000) @(posedge mclk_i);
		mismatches++;
		results();
	end
	initial begin
		rst_b_i = 1'b0;
		{modulation_input_i, modulation_kind_select_i, envelope_i, dec_data_i, dec_clk_i} = '0;
		{tx_done_i, rx_done_i, rx_byte_valid_i} = '0;
		rx_byte_i = 8'h00;
		repeat (12) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_b_i = 1'b1;
		u_mcu.wt(6);
		for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
		u_mcu.idle_clocks();
		chk({6'h0, miso_oe_b_o, miso_o}, 8'h02);
		u_mcu.half = 7;
		rd(5'h07, 8'h0e);
		u_mcu.half = 4;
		for (int i = 0; i < 5; i++) begin
			wr(5'h01, pc[i], 1'b0);
			chk({5'h0, proto_o}, {5'h0, pe[i]});
		end
		for (int i = 0; i < 6; i++) begin
			wr(5'h09, 8'h20 + 8'(i), 1'b0);
			chk({4'h0, ook_o, ask_depth_o}, {4'h0, i == 1, 3'(i)});
		end
		pulse_tx();
		chk({7'h0, irq_o}, 8'h01);
		u_mcu.sel();
		u_mcu.xfer(8'h6c, r);
		u_mcu.xfer(8'h00, r);
		chk(r, 8'h80);
		u_mcu.xfer(8'h00, r);
		u_mcu.stop();
		rd(5'h0c, 8'h00);
		chk({7'h0, irq_o}, 8'h00);
		// Fill until refused, then drain through the data register
		rx_byte_valid_i = 1'b1;
		for (int i = 0; i < 8; i++) begin
			rx_byte_i = 8'ha0 + 8'(n);
			if (rx_byte_ready_o === 1'b1) n++;
			@(negedge mclk_i);
		end
		rx_byte_valid_i = 1'b0;
		chk(8'(n), 8'h04);
		rd(5'h1c, 8'h04);
		u_mcu.sel();
		u_mcu.xfer(8'h7f, r);
		for (int i = 0; i < 4; i++) begin
			u_mcu.xfer(8'h00, r);
			chk(r, 8'ha0 + 8'(i));
		end
		u_mcu.stop();
		rd(5'h1c, 8'h00);
		rx_byte_valid_i = 1'b1;
		u_mcu.wt(2);
		rx_byte_valid_i = 1'b0;
		rd(5'h1c, 8'h02);
		u_mcu.sel();
		u_mcu.xfer(8'h8f, r);
		u_mcu.stop();
		rd(5'h1c, 8'h00);
		chk({7'h0, fifo_rst_seen}, 8'h01);
		wr(5'h09, 8'h61, 1'b0);
		wr(5'h01, 8'h08, 1'b0);
		wr(5'h00, 8'h41, 1'b1);
		u_mcu.xfer(8'h00, r);
		chk({6'h0, route_o}, {6'h0, RSDM_RT_FRONT_END});
		for (int i = 0; i < 2; i++) begin
			{modulation_input_i, modulation_kind_select_i, envelope_i} = {{2{i[0]}}, !i[0]};
			pulse_tx();
			chk({4'h0, modulator_o, ook_o, rx_data_o, rx_data_oe_b_o},
				{4'h0, i[0], i[0], !i[0], 1'b0});
			chk({7'h0, irq_o}, 8'h00);
		end
		wr(5'h07, 8'h55, 1'b1);
		u_mcu.stop();
		chk({6'h0, route_o}, {6'h0, RSDM_RT_NORMAL});
		rd(5'h00, 8'h01);
		rd(5'h07, 8'h0e);
		wr(5'h01, 8'h48, 1'b0);
		// No extra clocks here: the port stays live, so they would write zero to chip state
		wr(5'h00, 8'h41, 1'b1);
		for (int i = 0; i < 2; i++) begin
			{dec_data_i, dec_clk_i} = {i[0], !i[0]};
			u_mcu.wt(6);
			chk({4'h0, route_o == RSDM_RT_DECODED, rx_data_o, bit_clk_o, bit_clk_oe_b_o},
				{4'h0, 1'b1, i[0], !i[0], 1'b0});
		end
		u_mcu.stop();
		results();
	end
endmodule
